//--- common/irq_sleep_pkg.sv
// Package with register map, field layout and timing constants of the interrupt and sleep block.
package irq_sleep_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] SLEEP_COMMAND_OFS = 8'h12;
  localparam logic [7:0] INTERRUPT_ENABLE_OFS = 8'h13;
  localparam logic [7:0] INTERRUPT_FLAGS_OFS = 8'h14;
  localparam logic [7:0] PIN_INTERRUPT_ENABLE_OFS = 8'h18;
  localparam logic [7:0] PIN_INTERRUPT_FLAGS_OFS = 8'h19;

  // ----------------------------------------
  // Field positions and values
  // ----------------------------------------
  localparam int ENVELOPE_DETECT_BIT = 7;
  localparam int TIMER_A_OVERFLOW_BIT = 6;
  localparam int CAPTURE_EVENT_BIT = 5;
  localparam int TIMER_B_OVERFLOW_BIT = 4;
  localparam int TICK_TOP_BIT = 3;
  localparam int PIN_IRQ_COUNT = 2;
  localparam logic [7:0] SLEEP_KEY_VALUE = 8'hAA;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam logic [7:0] PIN_SYNC_RESET = 8'h00;

  // ----------------------------------------
  // Stack and vector addresses
  // ----------------------------------------
  localparam logic [8:0] STACK_HIGH_ADDR = 9'h1FF;
  localparam logic [8:0] STACK_LOW_ADDR = 9'h1FE;
  localparam logic [15:0] VECTOR_LOW_ADDR = 16'hFFFE;
  localparam logic [15:0] VECTOR_HIGH_ADDR = 16'hFFFF;

  // ----------------------------------------
  // Cycle counts
  // ----------------------------------------
  localparam int unsigned TICK_DIV_1024 = 1024;
  localparam int unsigned TICK_DIV_4096 = 4096;
  localparam int unsigned TICK_DIV_32768 = 32768;
  localparam int unsigned TICK_DIV_2097152 = 2097152;
  localparam int unsigned WAKE_HOLD_CYCLES = 32768;

endpackage

//--- dv/cpu_mem_model.sv
// Behavioural stack RAM and vector ROM that answer the block's memory reads.
`timescale 1ns/1ns
module cpu_mem_model
  import irq_sleep_pkg::*;
#(
  parameter logic [15:0] VEC_VALUE = 16'hC35A
) (
  // Clock
  input wire logic CLK,
  // Stack RAM
  input wire logic STACK_WE,
  input wire logic STACK_RE,
  input wire logic [8:0] STACK_ADDR,
  input wire logic [7:0] STACK_WDATA,
  output logic [7:0] STACK_RDATA,
  // Vector ROM
  input wire logic VEC_RE,
  input wire logic [15:0] VEC_ADDR,
  output logic [7:0] VEC_RDATA
);
  logic [7:0] stack_mem [512];
  logic [7:0] vec_byte;

  always @(posedge CLK) begin
    if (STACK_WE) begin
      stack_mem[STACK_ADDR] <= STACK_WDATA;
    end
  end

  // The sequencer takes read data at the edge that closes its strobe cycle, so reads
  // answer within that cycle. With the strobe low the bus shows the inverse, so a
  // sequencer that samples late cannot pick up the right byte by luck.
  assign STACK_RDATA = STACK_RE ? stack_mem[STACK_ADDR] : ~stack_mem[STACK_ADDR];
  assign vec_byte = (VEC_ADDR == VECTOR_HIGH_ADDR) ? VEC_VALUE[15:8] : VEC_VALUE[7:0];
  assign VEC_RDATA = VEC_RE ? vec_byte : ~vec_byte;
endmodule

//--- dv/irq_and_sleep_control_tb_top.sv
// Self-checking bench for the interrupt and sleep block with its memory partner.
`timescale 1ns/1ns
module irq_and_sleep_control_tb_top
  import irq_sleep_pkg::*;
;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  localparam int unsigned WH = 16;
  localparam logic [15:0] VEC = 16'hC35A;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] evt = 4'h0;
  logic [7:0] portb = 8'h00;
  logic insn_b = 1'b0;
  logic irq_dis = 1'b1;
  logic ret_req = 1'b0;
  logic [15:0] cpu_pc = 16'h0000;
  logic irq_req, seq_busy, load_pc, stack_we, stack_re, vec_re;
  logic clock_stop, lv_rst_off, cpu_hold, sys_rst;
  logic [15:0] new_pc, vec_addr;
  logic [8:0] stack_addr;
  logic [7:0] stack_wdata, stack_rdata, vec_rdata;
  logic [31:0] seed = 32'h84BF6D9F;
  int error_cnt = 0;
  int checks = 0;

  always #2 clk = ~clk;

  irq_and_sleep_control #(.DIV_A(64), .DIV_B(128), .DIV_C(256), .DIV_D(512), .WAKE_HOLD(WH))
  i_irq_and_sleep_control (
    .CLK(clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .ENVELOPE_EVT(evt[3]), .TIMER_A_OVF_EVT(evt[2]),
    .CAPTURE_EVT(evt[1]), .TIMER_B_OVF_EVT(evt[0]), .PORTB_PIN(portb), .INSN_BOUNDARY(insn_b),
    .IRQ_DISABLE(irq_dis), .RETURN_REQ(ret_req), .CPU_PC(cpu_pc), .IRQ_REQ(irq_req),
    .SEQ_BUSY(seq_busy), .LOAD_PC(load_pc), .NEW_PC(new_pc), .STACK_WE(stack_we),
    .STACK_RE(stack_re), .STACK_ADDR(stack_addr), .STACK_WDATA(stack_wdata),
    .STACK_RDATA(stack_rdata), .VEC_RE(vec_re), .VEC_ADDR(vec_addr), .VEC_RDATA(vec_rdata),
    .CLOCK_STOP(clock_stop), .LOW_VOLTAGE_RESET_DISABLE(lv_rst_off), .CPU_HOLD(cpu_hold),
    .SYSTEM_RESET(sys_rst)
  );

  cpu_mem_model #(.VEC_VALUE(VEC)) i_cpu_mem_model (
    .CLK(clk), .STACK_WE(stack_we), .STACK_RE(stack_re), .STACK_ADDR(stack_addr),
    .STACK_WDATA(stack_wdata), .STACK_RDATA(stack_rdata), .VEC_RE(vec_re),
    .VEC_ADDR(vec_addr), .VEC_RDATA(vec_rdata)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data are sampled at the edge that closes the cycle in which they stand.
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(what, {8'h00, exp}, {8'h00, reg_rdata & m});
  endtask

  task automatic pulse(input logic [3:0] e, input logic b, input logic r);
    @(posedge clk);
    evt <= e;
    insn_b <= b;
    ret_req <= r;
    @(posedge clk);
    evt <= 4'h0;
    insn_b <= 1'b0;
    ret_req <= 1'b0;
  endtask

  // Selector 0 waits for a PC load, 1 waits for the clock request to drop.
  task automatic wait_for(input int sel, input int lim);
    int n;
    n = 0;
    while (n < lim && !((sel == 0) ? load_pc === 1'b1 : clock_stop === 1'b0)) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      error_cnt++;
      $display("[FAIL] wait %0d expected done seen timeout", sel);
      end_sim();
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] en;
    logic [15:0] pc;
    int cnt;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rchk("enable reset", INTERRUPT_ENABLE_OFS, 8'hFF, REG_RESET_VALUE);
    rchk("flags reset", INTERRUPT_FLAGS_OFS, 8'hFF, REG_RESET_VALUE);
    rchk("pin enable reset", PIN_INTERRUPT_ENABLE_OFS, 8'hFF, 8'h00);
    rchk("pin flags reset", PIN_INTERRUPT_FLAGS_OFS, 8'hFF, 8'h00);
    rchk("sleep read", SLEEP_COMMAND_OFS, 8'hFF, 8'h00);
    rchk("unmapped read", 8'h20, 8'hFF, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      en = 8'(xs());
      wr(INTERRUPT_ENABLE_OFS, en);
      rchk("enable rw", INTERRUPT_ENABLE_OFS, 8'hFF, en);
      wr(PIN_INTERRUPT_ENABLE_OFS, en);
      rchk("pin enable rw", PIN_INTERRUPT_ENABLE_OFS, 8'hFF, en & 8'h03);
    end
    wr(PIN_INTERRUPT_ENABLE_OFS, 8'h00);
    $display("test enables done");
    // Timebase flags keep arriving, so only the upper nibble is compared here.
    for (int i = 0; i < 4; i++) begin
      en = 8'(xs()) & 8'hF0;
      wr(INTERRUPT_ENABLE_OFS, en);
      pulse(4'(1 << i), 1'b0, 1'b0);
      rchk("event flag", INTERRUPT_FLAGS_OFS, 8'hF0, 8'(1 << (4 + i)));
      chk("flag request", {15'h0, en[4 + i]}, {15'h0, irq_req});
      wr(INTERRUPT_FLAGS_OFS, 8'h0F);
      rchk("zero keeps", INTERRUPT_FLAGS_OFS, 8'hF0, 8'(1 << (4 + i)));
      wr(INTERRUPT_FLAGS_OFS, 8'(1 << (4 + i)));
      rchk("one clears", INTERRUPT_FLAGS_OFS, 8'hF0, 8'h00);
      chk("request gone", 16'h0, {15'h0, irq_req});
    end
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= INTERRUPT_FLAGS_OFS;
    reg_wdata <= 8'hF0;
    evt <= 4'b0101;
    @(posedge clk);
    reg_wr <= 1'b0;
    evt <= 4'h0;
    rchk("set beats clear", INTERRUPT_FLAGS_OFS, 8'hF0, 8'h50);
    $display("test flags done");
    wr(INTERRUPT_ENABLE_OFS, 8'h00);
    wr(INTERRUPT_FLAGS_OFS, 8'hFF);
    wr(PIN_INTERRUPT_ENABLE_OFS, 8'h02);
    portb <= 8'h02;
    repeat (10) @(posedge clk);
    rchk("pin flag", PIN_INTERRUPT_FLAGS_OFS, 8'hFF, 8'h02);
    chk("pin request", 16'h1, {15'h0, irq_req});
    wr(PIN_INTERRUPT_FLAGS_OFS, 8'h02);
    rchk("pin clear", PIN_INTERRUPT_FLAGS_OFS, 8'hFF, 8'h00);
    wr(PIN_INTERRUPT_ENABLE_OFS, 8'h00);
    wr(INTERRUPT_FLAGS_OFS, 8'h0F);
    repeat (520) @(posedge clk);
    rchk("tick flags", INTERRUPT_FLAGS_OFS, 8'h0F, 8'h0F);
    $display("test pins and ticks done");
    wr(INTERRUPT_FLAGS_OFS, 8'hFF);
    wr(INTERRUPT_ENABLE_OFS, 8'h40);
    pulse(4'b0100, 1'b0, 1'b0);
    repeat (4) @(posedge clk);
    chk("pending request", 16'h1, {15'h0, irq_req});
    chk("waits for boundary", 16'h0, {15'h0, seq_busy});
    pulse(4'h0, 1'b1, 1'b0);
    repeat (3) @(posedge clk);
    chk("masked entry", 16'h0, {15'h0, seq_busy});
    pc = 16'(xs());
    cpu_pc <= pc;
    irq_dis <= 1'b0;
    pulse(4'h0, 1'b1, 1'b0);
    @(posedge clk);
    chk("busy in entry", 16'h1, {15'h0, seq_busy});
    wait_for(0, 20);
    chk("vector", VEC, new_pc);
    chk("stack high", {8'h00, pc[15:8]}, {8'h00, i_cpu_mem_model.stack_mem[STACK_HIGH_ADDR]});
    chk("stack low", {8'h00, pc[7:0]}, {8'h00, i_cpu_mem_model.stack_mem[STACK_LOW_ADDR]});
    wr(INTERRUPT_FLAGS_OFS, 8'h40);
    pulse(4'h0, 1'b0, 1'b1);
    wait_for(0, 20);
    chk("return pc", pc, new_pc);
    chk("request served", 16'h0, {15'h0, irq_req});
    $display("test entry and return done");
    wr(SLEEP_COMMAND_OFS, SLEEP_KEY_VALUE);
    @(posedge clk);
    chk("clock stop", 16'h1, {15'h0, clock_stop});
    chk("supply reset off", 16'h1, {15'h0, lv_rst_off});
    repeat (8) @(posedge clk);
    chk("still asleep", 16'h1, {15'h0, clock_stop & cpu_hold});
    portb <= portb ^ 8'h20;
    wait_for(1, 20);
    cnt = 0;
    while (cpu_hold === 1'b1 && cnt < WH + 20) begin
      @(posedge clk);
      cnt++;
    end
    chk("wake hold", 16'h1, {15'h0, (cnt + 1 >= WH) && (cnt <= WH + 3)});
    $display("test sleep done");
    for (int i = 0; i < 3; i++) begin
      en = 8'(xs());
      if (en == SLEEP_KEY_VALUE) begin
        en = 8'h55;
      end
      wr(SLEEP_COMMAND_OFS, en);
      @(posedge clk);
      chk("system reset", 16'h1, {15'h0, sys_rst});
      @(posedge clk);
      chk("reset pulse end", 16'h0, {15'h0, sys_rst});
    end
    $display("test bad key done");
    end_sim();
  end
endmodule

//--- logic/irq_and_sleep_control.sv
// Interrupt flag, enable and request logic with CPU entry/return sequencing and sleep control.
`timescale 1ns/1ns
module irq_and_sleep_control
  import irq_sleep_pkg::*;
#(
  parameter int unsigned DIV_A = TICK_DIV_1024,
  parameter int unsigned DIV_B = TICK_DIV_4096,
  parameter int unsigned DIV_C = TICK_DIV_32768,
  parameter int unsigned DIV_D = TICK_DIV_2097152,
  parameter int unsigned WAKE_HOLD = WAKE_HOLD_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Peripheral events, one-cycle pulses
  input wire logic ENVELOPE_EVT,
  input wire logic TIMER_A_OVF_EVT,
  input wire logic CAPTURE_EVT,
  input wire logic TIMER_B_OVF_EVT,
  // Port B pins, asynchronous
  input wire logic [7:0] PORTB_PIN,
  // CPU side
  input wire logic INSN_BOUNDARY,
  input wire logic IRQ_DISABLE,
  input wire logic RETURN_REQ,
  input wire logic [15:0] CPU_PC,
  output logic IRQ_REQ,
  output logic SEQ_BUSY,
  output logic LOAD_PC,
  output logic [15:0] NEW_PC,
  // Stack and vector memory access
  output logic STACK_WE,
  output logic STACK_RE,
  output logic [8:0] STACK_ADDR,
  output logic [7:0] STACK_WDATA,
  input wire logic [7:0] STACK_RDATA,
  output logic VEC_RE,
  output logic [15:0] VEC_ADDR,
  input wire logic [7:0] VEC_RDATA,
  // Power control
  output logic CLOCK_STOP,
  output logic LOW_VOLTAGE_RESET_DISABLE,
  output logic CPU_HOLD,
  output logic SYSTEM_RESET
);

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  localparam int unsigned DIVS [4] = '{DIV_A, DIV_B, DIV_C, DIV_D};
  localparam int TB_W = $clog2(DIV_D);
  localparam int HOLD_W = $clog2(WAKE_HOLD + 1);

  if (DIV_A < 2 || DIV_A >= DIV_B || DIV_B >= DIV_C || DIV_C >= DIV_D ||
      (DIV_A & (DIV_A - 1)) != 0 || (DIV_B & (DIV_B - 1)) != 0 ||
      (DIV_C & (DIV_C - 1)) != 0 || (DIV_D & (DIV_D - 1)) != 0 || WAKE_HOLD < 1) begin : g_bad
    $error("Divider ratios must be rising powers of two and the hold at least one.");
  end

  typedef enum logic [10:0] {
    ST_IDLE = 11'h001,
    ST_PUSH_HI = 11'h002,
    ST_PUSH_LO = 11'h004,
    ST_VEC_LO = 11'h008,
    ST_VEC_HI = 11'h010,
    ST_JUMP = 11'h020,
    ST_POP_LO = 11'h040,
    ST_POP_HI = 11'h080,
    ST_RETURN = 11'h100,
    ST_SLEEP = 11'h200,
    ST_WAKE = 11'h400
  } seq_state_type;

  seq_state_type state_q;
  logic [7:0] enable_q;
  logic [7:0] flags_q;
  logic [PIN_IRQ_COUNT-1:0] pin_enable_q;
  logic [PIN_IRQ_COUNT-1:0] pin_flags_q;
  logic [TB_W-1:0] tb_count_q;
  logic [3:0] tick;
  logic [7:0] src_evt;
  logic [7:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_stable_q, pin_sleep_q;
  logic [7:0] pin_stable_d;
  logic [PIN_IRQ_COUNT-1:0] pin_evt;
  logic wr_sleep, wr_flags, wr_pflags, pending, take;
  logic [HOLD_W-1:0] hold_q;
  logic [7:0] byte_q;

  assign wr_sleep = REG_WR && REG_ADDR == SLEEP_COMMAND_OFS;
  assign wr_flags = REG_WR && REG_ADDR == INTERRUPT_FLAGS_OFS;
  assign wr_pflags = REG_WR && REG_ADDR == PIN_INTERRUPT_FLAGS_OFS;

  // ----------------------------------------
  // Timebase divider
  // ----------------------------------------
  // The divider is frozen while asleep, as the oscillator is stopped then.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tb_count_q <= '0;
    end else if (state_q != ST_SLEEP) begin
      tb_count_q <= tb_count_q + 1'b1;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_tick
    localparam int LW = $clog2(DIVS[i]);
    assign tick[TICK_TOP_BIT-i] = state_q != ST_SLEEP && &tb_count_q[LW-1:0];
  end

  assign src_evt = {ENVELOPE_EVT, TIMER_A_OVF_EVT, CAPTURE_EVT, TIMER_B_OVF_EVT, tick};

  // ----------------------------------------
  // Port B synchroniser
  // ----------------------------------------
  // A change is accepted only once the second and third stages agree.
  assign pin_stable_d = (pin_s2_q == pin_s3_q) ? pin_s3_q : pin_stable_q;
  assign pin_evt = pin_stable_d[PIN_IRQ_COUNT-1:0] ^ pin_stable_q[PIN_IRQ_COUNT-1:0];

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pin_s1_q <= PIN_SYNC_RESET;
      pin_s2_q <= PIN_SYNC_RESET;
      pin_s3_q <= PIN_SYNC_RESET;
      pin_stable_q <= PIN_SYNC_RESET;
    end else begin
      pin_s1_q <= PORTB_PIN;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_stable_q <= pin_stable_d;
    end
  end

  // ----------------------------------------
  // Enable and flag registers
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      enable_q <= REG_RESET_VALUE;
      pin_enable_q <= '0;
    end else if (REG_WR) begin
      if (REG_ADDR == INTERRUPT_ENABLE_OFS) begin
        enable_q <= REG_WDATA;
      end
      if (REG_ADDR == PIN_INTERRUPT_ENABLE_OFS) begin
        pin_enable_q <= REG_WDATA[PIN_IRQ_COUNT-1:0];
      end
    end
  end

  // A new event is ORed in after the clear, so it survives a same-cycle clear.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      flags_q <= REG_RESET_VALUE;
      pin_flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~(wr_flags ? REG_WDATA : 8'h00)) | src_evt;
      pin_flags_q <= (pin_flags_q & ~(wr_pflags ? REG_WDATA[PIN_IRQ_COUNT-1:0] : 2'h0))
                     | pin_evt;
    end
  end

  // All sources share one line; which one fired is found by software.
  assign pending = |(flags_q & enable_q) || |(pin_flags_q & pin_enable_q);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      IRQ_REQ <= 1'b0;
    end else begin
      IRQ_REQ <= pending;
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        INTERRUPT_ENABLE_OFS: REG_RDATA <= enable_q;
        INTERRUPT_FLAGS_OFS: REG_RDATA <= flags_q;
        PIN_INTERRUPT_ENABLE_OFS: REG_RDATA <= {6'h00, pin_enable_q};
        PIN_INTERRUPT_FLAGS_OFS: REG_RDATA <= {6'h00, pin_flags_q};
        default: REG_RDATA <= 8'h00;
      endcase
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  // ----------------------------------------
  // Entry, return and sleep sequencer
  // ----------------------------------------
  // Requests are sampled only at a boundary, so an instruction always completes.
  assign take = INSN_BOUNDARY && IRQ_REQ && !IRQ_DISABLE;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_q <= ST_IDLE;
      STACK_WE <= 1'b0;
      STACK_RE <= 1'b0;
      STACK_ADDR <= STACK_HIGH_ADDR;
      STACK_WDATA <= 8'h00;
      VEC_RE <= 1'b0;
      VEC_ADDR <= VECTOR_LOW_ADDR;
      LOAD_PC <= 1'b0;
      NEW_PC <= 16'h0000;
      byte_q <= 8'h00;
      hold_q <= '0;
      pin_sleep_q <= PIN_SYNC_RESET;
    end else begin
      STACK_WE <= 1'b0;
      STACK_RE <= 1'b0;
      VEC_RE <= 1'b0;
      LOAD_PC <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (wr_sleep && REG_WDATA == SLEEP_KEY_VALUE) begin
            state_q <= ST_SLEEP;
            pin_sleep_q <= pin_stable_q;
          end else if (RETURN_REQ) begin
            state_q <= ST_POP_LO;
            STACK_RE <= 1'b1;
            STACK_ADDR <= STACK_LOW_ADDR;
          end else if (take) begin
            state_q <= ST_PUSH_HI;
            STACK_WE <= 1'b1;
            STACK_ADDR <= STACK_HIGH_ADDR;
            STACK_WDATA <= CPU_PC[15:8];
            byte_q <= CPU_PC[7:0];
          end
        end
        ST_PUSH_HI: begin
          state_q <= ST_PUSH_LO;
          STACK_WE <= 1'b1;
          STACK_ADDR <= STACK_LOW_ADDR;
          STACK_WDATA <= byte_q;
        end
        ST_PUSH_LO: begin
          state_q <= ST_VEC_LO;
          VEC_RE <= 1'b1;
          VEC_ADDR <= VECTOR_LOW_ADDR;
        end
        ST_VEC_LO: begin
          state_q <= ST_VEC_HI;
          VEC_RE <= 1'b1;
          VEC_ADDR <= VECTOR_HIGH_ADDR;
          byte_q <= VEC_RDATA;
        end
        ST_VEC_HI: begin
          state_q <= ST_JUMP;
          LOAD_PC <= 1'b1;
          NEW_PC <= {VEC_RDATA, byte_q};
        end
        ST_POP_LO: begin
          state_q <= ST_POP_HI;
          STACK_RE <= 1'b1;
          STACK_ADDR <= STACK_HIGH_ADDR;
          byte_q <= STACK_RDATA;
        end
        ST_POP_HI: begin
          state_q <= ST_RETURN;
          LOAD_PC <= 1'b1;
          NEW_PC <= {STACK_RDATA, byte_q};
        end
        ST_JUMP, ST_RETURN: begin
          state_q <= ST_IDLE;
        end
        ST_SLEEP: begin
          if (pin_stable_q != pin_sleep_q) begin
            state_q <= ST_WAKE;
            hold_q <= HOLD_W'(WAKE_HOLD - 1);
          end
        end
        ST_WAKE: begin
          if (hold_q == '0) begin
            state_q <= ST_IDLE;
          end else begin
            hold_q <= hold_q - 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Power control outputs
  // ----------------------------------------
  // The sleep key is honoured only between sequences; a busy write is ignored.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CLOCK_STOP <= 1'b0;
      LOW_VOLTAGE_RESET_DISABLE <= 1'b0;
      CPU_HOLD <= 1'b0;
      SYSTEM_RESET <= 1'b0;
      SEQ_BUSY <= 1'b0;
    end else begin
      CLOCK_STOP <= (state_q == ST_IDLE && wr_sleep && REG_WDATA == SLEEP_KEY_VALUE) ||
                    (state_q == ST_SLEEP && pin_stable_q == pin_sleep_q);
      LOW_VOLTAGE_RESET_DISABLE <= (state_q == ST_IDLE && wr_sleep &&
                                    REG_WDATA == SLEEP_KEY_VALUE) ||
                                   (state_q == ST_SLEEP && pin_stable_q == pin_sleep_q);
      CPU_HOLD <= (state_q == ST_IDLE && wr_sleep && REG_WDATA == SLEEP_KEY_VALUE) ||
                  state_q == ST_SLEEP || (state_q == ST_WAKE && hold_q != '0);
      SYSTEM_RESET <= wr_sleep && REG_WDATA != SLEEP_KEY_VALUE;
      SEQ_BUSY <= !(state_q == ST_IDLE && !take && !RETURN_REQ) &&
                  state_q != ST_JUMP && state_q != ST_RETURN;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_event_sets_flag: assert property (ENVELOPE_EVT |=> flags_q[ENVELOPE_DETECT_BIT])
    else $error("Envelope event did not set its flag.");
  a_request_needs_enable: assert property ($rose(IRQ_REQ) |-> $past(pending))
    else $error("Request raised without an enabled flag.");
  a_no_request_masked: assert property (enable_q == 8'h00 && pin_enable_q == 2'h0
    |=> !IRQ_REQ)
    else $error("Request raised with every source disabled.");
  a_clear_one_flag: assert property (
    wr_flags && REG_WDATA[CAPTURE_EVENT_BIT] && !CAPTURE_EVT |=> !flags_q[CAPTURE_EVENT_BIT])
    else $error("Write of one did not clear the flag.");
  a_set_beats_clear: assert property (wr_flags && REG_WDATA[TIMER_B_OVERFLOW_BIT] &&
    TIMER_B_OVF_EVT |=> flags_q[TIMER_B_OVERFLOW_BIT])
    else $error("Event lost against a same-cycle clear.");
  a_zero_keeps_flag: assert property (wr_flags && !REG_WDATA[TIMER_A_OVERFLOW_BIT] &&
    flags_q[TIMER_A_OVERFLOW_BIT] |=> flags_q[TIMER_A_OVERFLOW_BIT])
    else $error("Write of zero disturbed a flag.");
  a_entry_pushes_pc: assert property (take && state_q == ST_IDLE
    && !RETURN_REQ && !wr_sleep |=> STACK_WE && STACK_ADDR == STACK_HIGH_ADDR
    ##1 STACK_WE && STACK_ADDR == STACK_LOW_ADDR ##1 VEC_RE && VEC_ADDR == VECTOR_LOW_ADDR
    ##1 VEC_RE && VEC_ADDR == VECTOR_HIGH_ADDR ##1 LOAD_PC)
    else $error("Interrupt entry sequence broken.");
  a_disable_blocks: assert property (IRQ_DISABLE && state_q == ST_IDLE && !RETURN_REQ
    |=> !STACK_WE)
    else $error("Request accepted while interrupts disabled.");
  a_return_pops: assert property (RETURN_REQ && state_q == ST_IDLE && !wr_sleep
    |=> STACK_RE && STACK_ADDR == STACK_LOW_ADDR ##1 STACK_RE && STACK_ADDR == STACK_HIGH_ADDR
    ##1 LOAD_PC && NEW_PC[7:0] == $past(STACK_RDATA, 2))
    else $error("Return did not restore the saved PC.");
  a_bad_key_resets: assert property (wr_sleep && REG_WDATA != SLEEP_KEY_VALUE
    |=> SYSTEM_RESET)
    else $error("Non-key sleep write did not reset.");
  a_sleep_stops_clock: assert property (wr_sleep && REG_WDATA == SLEEP_KEY_VALUE
    && state_q == ST_IDLE |=> CLOCK_STOP && LOW_VOLTAGE_RESET_DISABLE && state_q == ST_SLEEP)
    else $error("Sleep key did not stop the clock.");
  a_wake_holds_cpu: assert property (state_q == ST_SLEEP
    && pin_stable_q != pin_sleep_q |=> !CLOCK_STOP && CPU_HOLD)
    else $error("Wakeup did not restart clock under hold.");
  a_hold_counts: assert property (state_q == ST_WAKE && hold_q != '0
    |=> state_q == ST_WAKE && hold_q == $past(hold_q) - 1'b1)
    else $error("Wakeup hold counter misbehaved.");

  c_entry: cover property (take && state_q == ST_IDLE ##5 LOAD_PC);
  c_return: cover property (RETURN_REQ && state_q == ST_IDLE ##3 LOAD_PC);
  c_wake: cover property (state_q == ST_SLEEP ##1 state_q == ST_WAKE);
  c_pin_flag: cover property (pin_evt[1] ##1 pin_flags_q[1]);

endmodule
